// ### rtl/pwm_steer_consts.svh
// constants for the pwm output steering stage: offsets, fields, resets, timing
// assumes inclusion by bare name from the rtl files of this block
`ifndef PWM_STEER_CONSTS_SVH
`define PWM_STEER_CONSTS_SVH

// ****************************************************************
// register offsets (4-bit word address)
// ****************************************************************
`define OFS_CCP_CONTROL 4'h0
`define OFS_SHUTDOWN_CONTROL 4'h1
`define OFS_TIMER_SELECT_0 4'h2
`define OFS_TIMER_SELECT_1 4'h3
`define OFS_STEERING_CONTROL 4'h4
`define OFS_PWM_CONTROL 4'h5
`define OFS_PERIPHERAL_FLAG_REG 4'h6
`define OFS_DRIVER_ENABLE 4'h7
`define OFS_ALT_PIN_FUNCTION 4'h8

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CCP_CONTROL 8'h00
`define RST_SHUTDOWN_CONTROL 8'h00
`define RST_TIMER_SELECT 8'h00
`define RST_STEER_ENABLES 4'h1
`define RST_PWM_CONTROL 8'h00
`define RST_DRIVER_ENABLE 4'h0
`define RST_ALT_PIN_FUNCTION 4'h0

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_SHUTDOWN_EVENT 7
`define BIT_STEER_SYNC 4
`define BIT_AUTO_RESTART 7
`define BIT_TIMER_FLAG 0
`define BIT_CYCLE_DONE 1
`define FUNC_MODE_PWM 2'h3
`define OUT_CFG_SINGLE 2'h0
`define OUT_CFG_HALF 2'h2

// ****************************************************************
// timing
// ****************************************************************
// one instruction cycle is four oscillator periods, one clk each here
`define INSTR_CYCLE_CLKS 9'h004

`endif

// ### rtl/pwm_steer_pkg.sv
// types shared by the pwm output steering stage
// assumes nothing beyond a systemverilog compiler
package pwm_steer_pkg;

  // ****************************************************************
  // decoded operating mode of the output stage
  // ****************************************************************
  typedef enum logic [1:0] {MODE_IDLE, MODE_SINGLE, MODE_HALF} out_mode_t;

  // ****************************************************************
  // start-up tracking after enabling the pwm
  // ****************************************************************
  typedef enum logic [1:0] {START_OFF, START_FIRST, START_RUN} start_state_t;

endpackage : pwm_steer_pkg

// ### rtl/in_sync.sv
// two-flop synchroniser for the asynchronous shutdown source pins
// assumes the inputs come from pins outside the clk domain
`timescale 1ns/100ps
`default_nettype none

module in_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous in, synchronous out
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  logic [2:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // idle: int high, comps low
      meta_reg <= 3'h1;
      sync_out <= 3'h1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : in_sync

`default_nettype wire

// ### rtl/pin_driver.sv
// one output pin: polarity, shutdown state, driver enable, alternate location
// assumes all inputs are on the clk domain; out and oe are registered
`timescale 1ns/100ps
`default_nettype none

module pin_driver
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // signal and configuration
  input wire logic active_lvl,
  input wire logic routed,
  input wire logic invert,
  input wire logic shut,
  input wire logic [1:0] shut_state,
  input wire logic drv_en,
  input wire logic use_alt,
  // pin, primary and alternate location
  output logic main_out,
  output logic main_oe,
  output logic alt_out,
  output logic alt_oe
);

  logic lvl;
  logic oe;

  always_comb
  begin
    lvl = active_lvl ^ invert;
    oe = drv_en & routed;
    if (shut & routed)
    begin
      lvl = shut_state[0];
      oe = drv_en & ~shut_state[1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      main_out <= 1'b0;
      main_oe <= 1'b0;
      alt_out <= 1'b0;
      alt_oe <= 1'b0;
    end
    else
    begin
      main_out <= lvl & oe & ~use_alt;
      main_oe <= oe & ~use_alt;
      alt_out <= lvl & oe & use_alt;
      alt_oe <= oe & use_alt;
    end
  end

endmodule : pin_driver

`default_nettype wire

// ### rtl/pwm_output_steering.sv
// output steering and start-up control stage of an enhanced pwm unit
// assumes pwm_raw and period_start come from the period timer on clk,
// shutdown sources are asynchronous pins, registers on a plain strobe port
//
// Contract
// R1: sync select clear: new steering takes effect right after the write.
// R2: sync select set: new steering waits for the next period start.
// R3: two low mode bits pick polarity for pair A/C and pair B/D.
// R4: firmware sets polarity before enabling the pin drivers.
// R5: firmware waits one full pwm cycle before enabling the pin drivers.
// R6: timer flag sets as the second period after enabling begins.
// R7: after reset every pin is undriven until firmware enables it.
// R8: alternate pin function register moves chosen outputs to alternate pins.
// R9: shutdown register: event flag bit 7, source select, two pair states.
// R10: steering register: sync bit 4, enables D..A bits 3..0, rest zero.
// R11: single mode: every set enable routes the modulated signal to its pin.
// R12: shutdown event sets the flag and forces enabled pins to their states.
// R13: auto-restart clears the flag when the condition goes; resume next period.
// R14: half-bridge: inactive-to-active edges delayed by dead-band instruction cycles.
// R15: synchronised steering keeps writes in a shadow, copied on period start.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_steer_consts.svh"

module pwm_output_steering
  import pwm_steer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // from period timer and duty comparator
  input wire logic pwm_raw,
  input wire logic period_start,
  // shutdown source pins
  input wire logic int_pin_n,
  input wire logic [1:0] comp_out,
  // to period timer and duty comparator
  output logic [1:0] duty_low_bits,
  output logic [1:0] timer_select,
  // output pins, index 0..3 is out_a..out_d
  output logic [3:0] pin_main_out,
  output logic [3:0] pin_main_oe,
  output logic [3:0] pin_alt_out,
  output logic [3:0] pin_alt_oe,
  // status
  output logic period_timer_flag,
  output logic shutdown_event_flag
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] ccp_control_reg;
  logic [2:0] shutdown_source_select_reg;
  logic [1:0] pair_ac_shutdown_state_reg;
  logic [1:0] pair_bd_shutdown_state_reg;
  logic [7:0] timer_select_0_reg;
  logic [1:0] timer_select_1_reg;
  logic steer_sync_select_reg;
  logic [3:0] steer_shadow_reg;
  logic [3:0] pin_steer_enables_reg;
  logic auto_restart_enable_reg;
  logic [6:0] deadband_count_reg;
  logic [3:0] driver_enable_reg;
  logic [3:0] alt_pin_function_reg;
  logic shut_hold_reg;
  logic pwm_q_reg;
  logic [8:0] db_cnt_reg;
  start_state_t start_reg;

  logic [1:0] polarity_mode_bits;
  logic [1:0] function_mode_bits;
  logic [1:0] output_config_bits;
  logic [2:0] src_sync;
  logic shut_cond;
  logic shut_now;
  logic wr_shutdown;
  logic wr_steer;
  logic wr_flag;
  logic [8:0] db_target;
  logic db_done;
  out_mode_t mode;
  logic [3:0] lvl;
  logic [3:0] routed;
  logic [3:0] pin_inv;
  logic [1:0] pin_state [4];

  assign polarity_mode_bits = ccp_control_reg[1:0];
  assign function_mode_bits = ccp_control_reg[3:2];
  assign output_config_bits = ccp_control_reg[7:6];
  assign wr_shutdown = reg_wr && (reg_addr == `OFS_SHUTDOWN_CONTROL);
  assign wr_steer = reg_wr && (reg_addr == `OFS_STEERING_CONTROL);
  assign wr_flag = reg_wr && (reg_addr == `OFS_PERIPHERAL_FLAG_REG);

  // ****************************************************************
  // plain configuration registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ccp_control_reg <= `RST_CCP_CONTROL;
      timer_select_0_reg <= `RST_TIMER_SELECT;
      timer_select_1_reg <= 2'h0;
      auto_restart_enable_reg <= 1'b0;
      deadband_count_reg <= 7'h00;
      driver_enable_reg <= `RST_DRIVER_ENABLE; // see R7
      alt_pin_function_reg <= `RST_ALT_PIN_FUNCTION;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `OFS_CCP_CONTROL: ccp_control_reg <= reg_wdata;
        `OFS_TIMER_SELECT_0: timer_select_0_reg <= reg_wdata;
        `OFS_TIMER_SELECT_1: timer_select_1_reg <= reg_wdata[1:0];
        `OFS_PWM_CONTROL:
        begin
          auto_restart_enable_reg <= reg_wdata[`BIT_AUTO_RESTART];
          deadband_count_reg <= reg_wdata[6:0]; // see R14
        end
        `OFS_DRIVER_ENABLE: driver_enable_reg <= reg_wdata[3:0];
        `OFS_ALT_PIN_FUNCTION: alt_pin_function_reg <= reg_wdata[3:0]; // see R8
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      duty_low_bits <= 2'h0;
      timer_select <= 2'h0;
    end
    else
    begin
      duty_low_bits <= ccp_control_reg[5:4];
      timer_select <= timer_select_0_reg[1:0];
    end
  end

  // ****************************************************************
  // shutdown sources and event flag
  // ****************************************************************
  in_sync u_sync
  (
    .clk(clk),
    .srst(srst),
    .async_in({comp_out, int_pin_n}),
    .sync_out(src_sync)
  );

  // select bit 2 picks the low-active int pin, bits 0 and 1 the comparators
  assign shut_cond = (shutdown_source_select_reg[2] & ~src_sync[0])
                   | (shutdown_source_select_reg[0] & src_sync[1])
                   | (shutdown_source_select_reg[1] & src_sync[2]);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shutdown_source_select_reg <= 3'h0;
      pair_ac_shutdown_state_reg <= 2'h0;
      pair_bd_shutdown_state_reg <= 2'h0;
    end
    else if (wr_shutdown)
    begin
      shutdown_source_select_reg <= reg_wdata[6:4]; // see R9
      pair_ac_shutdown_state_reg <= reg_wdata[3:2]; // see R9
      pair_bd_shutdown_state_reg <= reg_wdata[1:0]; // see R9
    end
  end

  // a live condition beats both a firmware clear and the auto-restart clear
  always_ff @(posedge clk)
  begin
    if (srst)
      shutdown_event_flag <= 1'b0;
    else if (shut_cond)
      shutdown_event_flag <= 1'b1; // see R12
    else if (wr_shutdown)
      shutdown_event_flag <= reg_wdata[`BIT_SHUTDOWN_EVENT];
    else if (auto_restart_enable_reg)
      shutdown_event_flag <= 1'b0; // see R13
  end

  // keeps pins in shutdown until a period boundary after the flag drops
  always_ff @(posedge clk)
  begin
    if (srst)
      shut_hold_reg <= 1'b0;
    else if (shut_cond || shutdown_event_flag)
      shut_hold_reg <= 1'b1;
    else if (period_start)
      shut_hold_reg <= 1'b0; // see R13
  end

  // the raw condition goes straight to the pins, not waiting for the flag
  assign shut_now = shut_cond | shutdown_event_flag | shut_hold_reg; // see R12

  // ****************************************************************
  // steering: shadow and active enables
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      steer_sync_select_reg <= 1'b0;
      steer_shadow_reg <= `RST_STEER_ENABLES;
    end
    else if (wr_steer)
    begin
      steer_sync_select_reg <= reg_wdata[`BIT_STEER_SYNC]; // see R10
      steer_shadow_reg <= reg_wdata[3:0]; // see R15
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pin_steer_enables_reg <= `RST_STEER_ENABLES;
    else if (wr_steer && !reg_wdata[`BIT_STEER_SYNC])
      pin_steer_enables_reg <= reg_wdata[3:0]; // see R1
    else if (period_start && steer_sync_select_reg)
      pin_steer_enables_reg <= steer_shadow_reg; // see R2, R15
  end

  // ****************************************************************
  // start-up tracking and period timer flag
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      start_reg <= START_OFF;
    else if (function_mode_bits != `FUNC_MODE_PWM)
      start_reg <= START_OFF;
    else if (period_start)
    begin
      unique case (start_reg)
        START_OFF: start_reg <= START_FIRST;
        START_FIRST: start_reg <= START_RUN; // see R6
        START_RUN: start_reg <= START_RUN;
      endcase
    end
  end

  // hardware set wins over a firmware clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      period_timer_flag <= 1'b0;
    else if (period_start && (start_reg != START_OFF)
             && (function_mode_bits == `FUNC_MODE_PWM))
      period_timer_flag <= 1'b1; // see R6, R5
    else if (wr_flag)
      period_timer_flag <= reg_wdata[`BIT_TIMER_FLAG];
  end

  // ****************************************************************
  // dead-band delay for half-bridge
  // ****************************************************************
  // counter restarts on every raw edge and outside half-bridge; both outputs stay
  // inactive until it reaches four times the programmed count, so edges never overlap
  assign db_target = {2'h0, deadband_count_reg} * `INSTR_CYCLE_CLKS;
  assign db_done = (db_cnt_reg >= db_target);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pwm_q_reg <= 1'b0;
      db_cnt_reg <= 9'h000;
    end
    else
    begin
      pwm_q_reg <= pwm_raw;
      if ((pwm_raw != pwm_q_reg) || (mode != MODE_HALF))
        db_cnt_reg <= 9'h000; // see R14
      else if (!db_done)
        db_cnt_reg <= db_cnt_reg + 9'h001;
    end
  end

  // ****************************************************************
  // output mode and per-pin routing
  // ****************************************************************
  always_comb
  begin
    mode = MODE_IDLE;
    if (function_mode_bits == `FUNC_MODE_PWM)
    begin
      if (output_config_bits == `OUT_CFG_SINGLE)
        mode = MODE_SINGLE;
      else if (output_config_bits == `OUT_CFG_HALF)
        mode = MODE_HALF;
    end
  end

  always_comb
  begin
    lvl = 4'h0;
    routed = 4'h0;
    unique case (mode)
      MODE_SINGLE:
      begin
        lvl = {4{pwm_raw}}; // see R11
        routed = pin_steer_enables_reg; // see R11
      end
      MODE_HALF:
      begin
        lvl = {2'h0, ~pwm_q_reg & db_done, pwm_q_reg & db_done}; // see R14
        routed = 4'h3;
      end
      MODE_IDLE:
      begin
        lvl = 4'h0;
        routed = 4'h0;
      end
    endcase
  end

  // bit 1 inverts pair A/C, bit 0 inverts pair B/D
  assign pin_inv = {polarity_mode_bits[0], polarity_mode_bits[1],
                    polarity_mode_bits[0], polarity_mode_bits[1]}; // see R3
  assign pin_state[0] = pair_ac_shutdown_state_reg;
  assign pin_state[1] = pair_bd_shutdown_state_reg;
  assign pin_state[2] = pair_ac_shutdown_state_reg;
  assign pin_state[3] = pair_bd_shutdown_state_reg;

  // pins are only driven once firmware sets their driver enable
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_pin
      pin_driver u_pin
      (
        .clk(clk),
        .srst(srst),
        .active_lvl(lvl[gi]),
        .routed(routed[gi]),
        .invert(pin_inv[gi]),
        .shut(shut_now), // see R12
        .shut_state(pin_state[gi]),
        .drv_en(driver_enable_reg[gi]), // see R7, R4
        .use_alt(alt_pin_function_reg[gi]), // see R8
        .main_out(pin_main_out[gi]),
        .main_oe(pin_main_oe[gi]),
        .alt_out(pin_alt_out[gi]),
        .alt_oe(pin_alt_oe[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // register read port, data one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `OFS_CCP_CONTROL: reg_rdata <= ccp_control_reg;
        `OFS_SHUTDOWN_CONTROL:
          reg_rdata <= {shutdown_event_flag, shutdown_source_select_reg,
                        pair_ac_shutdown_state_reg, pair_bd_shutdown_state_reg};
        `OFS_TIMER_SELECT_0: reg_rdata <= timer_select_0_reg;
        `OFS_TIMER_SELECT_1: reg_rdata <= {6'h00, timer_select_1_reg};
        `OFS_STEERING_CONTROL:
          reg_rdata <= {3'h0, steer_sync_select_reg, steer_shadow_reg}; // see R10
        `OFS_PWM_CONTROL: reg_rdata <= {auto_restart_enable_reg, deadband_count_reg};
        `OFS_PERIPHERAL_FLAG_REG:
          reg_rdata <= {6'h00, start_reg == START_RUN, period_timer_flag};
        `OFS_DRIVER_ENABLE: reg_rdata <= {4'h0, driver_enable_reg};
        `OFS_ALT_PIN_FUNCTION: reg_rdata <= {4'h0, alt_pin_function_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule : pwm_output_steering

`default_nettype wire

// ### dv/pwm_steer_asserts.sv
// port-level assertions for the pwm output steering stage
// assumes binding into pwm_output_steering on a single clk domain
`timescale 1ns/100ps
`default_nettype none
`include "pwm_steer_consts.svh"

module pwm_steer_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // timer side
  input wire logic pwm_raw,
  input wire logic period_start,
  // pins and status
  input wire logic [3:0] pin_main_out,
  input wire logic [3:0] pin_main_oe,
  input wire logic [3:0] pin_alt_oe,
  input wire logic period_timer_flag,
  input wire logic shutdown_event_flag
);
  logic [7:0] ccp_reg;
  logic [7:0] sdc_reg;
  logic [3:0] drv_reg;
  logic [3:0] alt_reg;
  logic shut_seen_reg;
  // ****************************************************************
  // copies of written configuration
  // ****************************************************************
  // values only: refused writes are not modelled, so only plain fields are used
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ccp_reg <= 8'h00;
      sdc_reg <= 8'h00;
      drv_reg <= 4'h0;
      alt_reg <= 4'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `OFS_CCP_CONTROL) ccp_reg <= reg_wdata;
      if (reg_addr == `OFS_SHUTDOWN_CONTROL) sdc_reg <= reg_wdata;
      if (reg_addr == `OFS_DRIVER_ENABLE) drv_reg <= reg_wdata[3:0];
      if (reg_addr == `OFS_ALT_PIN_FUNCTION) alt_reg <= reg_wdata[3:0];
    end
  end
  // shutdown hold may outlive the flag, so polarity is judged only before one
  always_ff @(posedge clk)
  begin
    if (srst) shut_seen_reg <= 1'b0;
    else if (shutdown_event_flag) shut_seen_reg <= 1'b1;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_out_needs_oe: assert property ((pin_main_out & ~pin_main_oe) == 4'h0)
    else $error("pin level high while pin undriven");
  chk_reset_quiet: assert property ($fell(srst) |-> (pin_main_oe | pin_alt_oe) == 4'h0)
    else $error("pin driven right after reset");
  chk_drv_gates: assert property (((pin_main_oe | pin_alt_oe) & ~$past(drv_reg)) == 4'h0)
    else $error("pin driven without driver enable");
  chk_alt_location: assert property (((pin_alt_oe & ~$past(alt_reg))
    | (pin_main_oe & $past(alt_reg))) == 4'h0)
    else $error("pin driven at wrong location");
  chk_steer_upper: assert property ($past(reg_rd)
    && $past(reg_addr) == `OFS_STEERING_CONTROL |-> reg_rdata[7:5] == 3'h0)
    else $error("steering upper bits not zero");
  chk_steer_now: assert property (reg_wr && reg_addr == `OFS_STEERING_CONTROL
    && !reg_wdata[4] && ccp_reg[7:2] == 6'h03
    |-> ##2 ({4'h0, pin_main_oe | pin_alt_oe} & ~$past(reg_wdata, 2)) == 8'h00)
    else $error("steering removal not applied at once");
  chk_steer_defer: assert property (reg_wr && reg_addr == `OFS_STEERING_CONTROL
    && reg_wdata[4] ##1 !period_start [*2] |-> $stable(pin_main_oe))
    else $error("synchronised steering applied early");
  chk_bd_hiz: assert property ($rose(shutdown_event_flag)
    && !$past(reg_wr) && sdc_reg[1] |-> ((pin_main_oe | pin_alt_oe) & 4'hA) == 4'h0)
    else $error("pair b/d not released in shutdown");
  chk_flag_cause: assert property ($rose(period_timer_flag)
    |-> $past(period_start) || $past(reg_wr))
    else $error("timer flag set without period start");
  chk_polarity: assert property (pin_main_oe[1:0] == 2'h3 && !shut_seen_reg
    && $past(ccp_reg) ==? 8'b000011zz |-> pin_main_out[1:0] ==
    ({$past(pwm_raw), $past(pwm_raw)} ^ {$past(ccp_reg[0]), $past(ccp_reg[1])}))
    else $error("pin a/b polarity wrong");
  cov_shutdown: cover property ($rose(shutdown_event_flag));
  cov_timer_flag: cover property ($rose(period_timer_flag));
  cov_sync_write: cover property (reg_wr && reg_addr == `OFS_STEERING_CONTROL && reg_wdata[4]);
endmodule : pwm_steer_asserts

bind pwm_output_steering pwm_steer_asserts chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pwm_raw(pwm_raw), .period_start(period_start), .pin_main_out(pin_main_out),
  .pin_main_oe(pin_main_oe), .pin_alt_oe(pin_alt_oe), .period_timer_flag(period_timer_flag),
  .shutdown_event_flag(shutdown_event_flag));
`default_nettype wire

// ### dv/switch_driver_model.sv
// model of the external switch drivers on the four pwm pins
// assumes a pull-down on every pin, so a floating pin keeps its switch off
`timescale 1ns/100ps
`default_nettype none

module switch_driver_model
(
  // pins from the output stage
  input wire logic [3:0] main_out,
  input wire logic [3:0] main_oe,
  input wire logic [3:0] alt_out,
  input wire logic [3:0] alt_oe,
  // levels seen at the switch gates
  output logic [3:0] main_lvl,
  output logic [3:0] alt_lvl
);
  assign main_lvl = main_out & main_oe;
  assign alt_lvl = alt_out & alt_oe;
endmodule : switch_driver_model
`default_nettype wire

// ### dv/pwm_output_steering_bench.sv
// self-checking bench for the pwm output steering stage
// assumes design, checker and switch model are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "pwm_steer_consts.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end

module pwm_output_steering_bench;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] rst; logic [7:0] rw;} row_t;
  logic clk, srst, reg_wr, reg_rd, pwm_raw, period_start, int_pin_n;
  logic period_timer_flag, shutdown_event_flag;
  logic [1:0] comp_out, duty_low_bits, timer_select;
  logic [3:0] reg_addr, pin_main_out, pin_main_oe, pin_alt_out, pin_alt_oe, lvl, alt_lvl;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  int errors = 0;
  int checks = 0;
  row_t rows [10] = '{'{4'h0, 8'hFF, 8'h00, 8'hFF}, '{4'h1, 8'h3F, 8'h00, 8'h3F},
    '{4'h2, 8'hFF, 8'h00, 8'hFF}, '{4'h3, 8'hFF, 8'h00, 8'h03}, '{4'h4, 8'hFF, 8'h01, 8'h1F},
    '{4'h5, 8'h7F, 8'h00, 8'h7F}, '{4'h6, 8'h00, 8'h00, 8'h00}, '{4'h7, 8'hFF, 8'h00, 8'h0F},
    '{4'h8, 8'hFF, 8'h00, 8'h0F}, '{4'h9, 8'hFF, 8'h00, 8'h00}};

  pwm_output_steering uut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_raw(pwm_raw),
    .period_start(period_start), .int_pin_n(int_pin_n), .comp_out(comp_out),
    .duty_low_bits(duty_low_bits), .timer_select(timer_select), .pin_main_out(pin_main_out),
    .pin_main_oe(pin_main_oe), .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe),
    .period_timer_flag(period_timer_flag), .shutdown_event_flag(shutdown_event_flag));
  switch_driver_model sw (.main_out(pin_main_out), .main_oe(pin_main_oe), .alt_out(pin_alt_out),
    .alt_oe(pin_alt_oe), .main_lvl(lvl), .alt_lvl(alt_lvl));

  // ****************************************************************
  // bus and timer tasks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic pstart;
    @(posedge clk);
    period_start <= 1'b1;
    @(posedge clk);
    period_start <= 1'b0;
    #1;
  endtask : pstart
  task automatic rst;
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask : rst
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run is under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {srst, reg_wr, reg_rd, pwm_raw, period_start, int_pin_n} = 6'b100001;
    {comp_out, reg_addr, reg_wdata} = '0;
    rst();
    for (int i = 0; i < 10; i++)
    begin
      rd(rows[i].a);
      `CHK("reset value", rows[i].rst, rd_val)
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK("read back", rows[i].rw, rd_val)
    end
    `CHK("duty and timer", 4'hF, {duty_low_bits, timer_select})
    rst();
    step(1);
    `CHK("pins after reset", 8'h00, {pin_main_oe, pin_alt_oe})
    wr(`OFS_CCP_CONTROL, 8'h0C);
    pstart();
    `CHK("timer flag first period", 1'b0, period_timer_flag)
    pstart();
    `CHK("timer flag second period", 1'b1, period_timer_flag)
    wr(`OFS_STEERING_CONTROL, 8'h03);
    for (int p = 3; p >= 0; p--)
    begin
      wr(`OFS_DRIVER_ENABLE, 8'h00);
      wr(`OFS_CCP_CONTROL, {6'h03, p[1:0]});
      wr(`OFS_DRIVER_ENABLE, 8'h03);
      for (int v = 0; v < 2; v++)
      begin
        pwm_raw <= v[0];
        step(2);
        `CHK("pin a/b level", {v[0] ^ p[0], v[0] ^ p[1]}, lvl[1:0])
      end
    end
    wr(`OFS_STEERING_CONTROL, 8'h01);
    step(1);
    `CHK("immediate steer off", 1'b0, pin_main_oe[1])
    wr(`OFS_STEERING_CONTROL, 8'h13);
    step(3);
    `CHK("sync steer held", 1'b0, pin_main_oe[1])
    rd(`OFS_STEERING_CONTROL);
    `CHK("steer shadow", 8'h13, rd_val)
    pstart();
    step(1);
    `CHK("sync steer on period", 1'b1, pin_main_oe[1])
    wr(`OFS_ALT_PIN_FUNCTION, 8'h02);
    step(1);
    `CHK("alternate location", 3'b101, {pin_alt_oe[1], pin_main_oe[1], alt_lvl[1]})
    wr(`OFS_ALT_PIN_FUNCTION, 8'h00);
    wr(`OFS_PWM_CONTROL, 8'h80);
    wr(`OFS_SHUTDOWN_CONTROL, 8'h46);
    int_pin_n <= 1'b0;
    step(5);
    `CHK("shutdown states", 3'b110, {shutdown_event_flag, lvl[0], pin_main_oe[1]})
    rd(`OFS_SHUTDOWN_CONTROL);
    `CHK("shutdown reg", 8'hC6, rd_val)
    wr(`OFS_SHUTDOWN_CONTROL, 8'h46);
    step(2);
    `CHK("flag kept in condition", 1'b1, shutdown_event_flag)
    int_pin_n <= 1'b1;
    pwm_raw <= 1'b0;
    step(5);
    `CHK("auto restart held", 2'b01, {shutdown_event_flag, lvl[0]})
    pstart();
    step(1);
    `CHK("resume on period", 1'b0, lvl[0])
    wr(`OFS_PWM_CONTROL, 8'h02);
    wr(`OFS_CCP_CONTROL, 8'h8C);
    pwm_raw <= 1'b1;
    step(4);
    `CHK("dead band wait", 2'b00, lvl[1:0])
    step(8);
    `CHK("dead band done", 2'b01, lvl[1:0])
    tally_and_finish();
  end
endmodule : pwm_output_steering_bench
`default_nettype wire
